// *** rtl/pmc_pkg.sv ***
package pmc_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] PMC_OFS_MODE_CTRL = 5'h00;
    localparam logic [4:0] PMC_OFS_PAIR_SKEW = 5'h1d;
    localparam logic [4:0] PMC_OFS_RSVD_30 = 5'h1e;
    localparam logic [4:0] PMC_OFS_RSVD_31 = 5'h1f;

    // ----------------------------------------------------------------
    // mode control bit positions
    // ----------------------------------------------------------------
    localparam int PMC_B_SW_RESET = 15;
    localparam int PMC_B_LOOPBACK = 14;
    localparam int PMC_B_SPEED_LSB = 13;
    localparam int PMC_B_ANEG_EN = 12;
    localparam int PMC_B_PWR_DOWN = 11;
    localparam int PMC_B_ISOLATE = 10;
    localparam int PMC_B_ANEG_RESTART = 9;
    localparam int PMC_B_DUPLEX = 8;
    localparam int PMC_B_COL_TEST = 7;
    localparam int PMC_B_SPEED_MSB = 6;

    // skew fields: 3 bits per pair, one reserved bit above, pair a on top
    localparam int PMC_SKEW_W = 3;
    localparam int PMC_SKEW_STRIDE = 4;
    localparam int PMC_PAIRS = 4;

    typedef enum logic [1:0] {
        PMC_SPD_10 = 2'h0,
        PMC_SPD_100 = 2'h1,
        PMC_SPD_1000 = 2'h2,
        PMC_SPD_RSVD = 2'h3
    } pmc_speed_t;

    typedef struct packed {
        logic loopback;
        pmc_speed_t speed;
        logic aneg_en;
        logic power_down;
        logic isolate;
        logic duplex;
        logic col_test;
    } pmc_ctrl_t;

    localparam pmc_ctrl_t PMC_CTRL_RESET = '{
        loopback: 1'b0,
        speed: PMC_SPD_1000,
        aneg_en: 1'b1,
        power_down: 1'b0,
        isolate: 1'b0,
        duplex: 1'b0,
        col_test: 1'b0
    };

    // bits of the mode control word that may be reset-sticky
    localparam logic [15:0] PMC_STICKY_MASK_DEF = 16'h0000;

    typedef struct packed {
        logic en;
        logic er;
        logic [7:0] data;
    } pmc_mac_tx_t;

    typedef struct packed {
        logic dv;
        logic er;
        logic [7:0] data;
    } pmc_mac_rx_t;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int PMC_CLK_MHZ = 200;
    localparam int PMC_BIT_NS_FAST = 1;
    localparam int PMC_COL_RISE_BITS = 512;
    localparam int PMC_COL_FALL_BITS = 4;
    localparam int PMC_SYNC_LAT = 3;
    localparam int PMC_COL_RISE_CYC = (PMC_COL_RISE_BITS * PMC_BIT_NS_FAST * PMC_CLK_MHZ) / 1000;
    localparam int PMC_COL_FALL_CYC_RAW = (PMC_COL_FALL_BITS * PMC_BIT_NS_FAST * PMC_CLK_MHZ) / 1000;
    localparam int PMC_COL_FALL_CYC = (PMC_COL_FALL_CYC_RAW < 1) ? 1 : PMC_COL_FALL_CYC_RAW;
    localparam int PMC_COL_RISE_WAIT = PMC_COL_RISE_CYC - PMC_SYNC_LAT;

    function automatic logic [15:0] pmc_ctrl_to_word(input pmc_ctrl_t c);
        logic [15:0] w;
        w = 16'h0000;
        w[PMC_B_LOOPBACK] = c.loopback;
        w[PMC_B_SPEED_MSB] = c.speed[1];
        w[PMC_B_SPEED_LSB] = c.speed[0];
        w[PMC_B_ANEG_EN] = c.aneg_en;
        w[PMC_B_PWR_DOWN] = c.power_down;
        w[PMC_B_ISOLATE] = c.isolate;
        w[PMC_B_DUPLEX] = c.duplex;
        w[PMC_B_COL_TEST] = c.col_test;
        return w;
    endfunction : pmc_ctrl_to_word

    function automatic pmc_ctrl_t pmc_word_to_ctrl(input logic [15:0] w);
        pmc_ctrl_t c;
        c.loopback = w[PMC_B_LOOPBACK];
        c.speed = pmc_speed_t'({w[PMC_B_SPEED_MSB], w[PMC_B_SPEED_LSB]});
        c.aneg_en = w[PMC_B_ANEG_EN];
        c.power_down = w[PMC_B_PWR_DOWN];
        c.isolate = w[PMC_B_ISOLATE];
        c.duplex = w[PMC_B_DUPLEX];
        c.col_test = w[PMC_B_COL_TEST];
        return c;
    endfunction : pmc_word_to_ctrl

endpackage : pmc_pkg

// *** rtl/pmc_col_test.sv ***
`timescale 1ns/1ps
module pmc_col_test #(
    parameter int RISE_WAIT = pmc_pkg::PMC_COL_RISE_WAIT
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic enable, // collision test mode on
    input wire logic tx_en, // synchronised transmit enable
    output logic col // test collision indication
);
    import pmc_pkg::*;

    localparam int CW = $clog2(RISE_WAIT + 1);
    localparam logic [CW-1:0] WAIT_LAST = CW'(RISE_WAIT - 1);

    typedef enum logic [2:0] {
        PMC_CT_IDLE = 3'b001,
        PMC_CT_WAIT = 3'b010,
        PMC_CT_ACTIVE = 3'b100
    } pmc_ct_state_t;

    typedef struct packed {
        pmc_ct_state_t st;
        logic [CW-1:0] cnt;
        logic col;
    } pmc_ct_t;

    pmc_ct_t s;
    pmc_ct_t next_s;

    always_comb begin
        next_s = s;
        case (s.st)
            PMC_CT_IDLE: begin
                next_s.cnt = '0;
                if (enable && tx_en) begin
                    next_s.st = PMC_CT_WAIT;
                end
            end
            PMC_CT_WAIT: begin
                next_s.cnt = s.cnt + CW'(1);
                if (!enable || !tx_en) begin
                    next_s.st = PMC_CT_IDLE;
                end else if (s.cnt >= WAIT_LAST) begin
                    next_s.st = PMC_CT_ACTIVE;
                end
            end
            PMC_CT_ACTIVE: begin
                if (!enable || !tx_en) begin
                    next_s.st = PMC_CT_IDLE;
                end
            end
            default: begin
                next_s.st = PMC_CT_IDLE;
            end
        endcase
        next_s.col = (next_s.st == PMC_CT_ACTIVE);
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{st: PMC_CT_IDLE, cnt: '0, col: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign col = s.col;

endmodule : pmc_col_test

// *** rtl/pmc_mode_ctrl.sv ***
`timescale 1ns/1ps
// Functional notes
// - writing one to bit 15 starts software reset; bit self-clears, reads zero.
// - after software reset the block is ready for the next access at once.
// - software reset restores defaults, sticky bits kept while sticky enable is set.
// - software reset leaves analog references and PLL powered; hardware reset does not.
// - loopback returns MAC transmit data as receive data, nothing to the line.
// - in loopback the speed comes from the forced speed bits.
// - forced speed is bit 6 msb, bit 13 lsb; 10 selects 1000, reset 10.
// - forced speed applies only while negotiation enable is zero or loopback is set.
// - 1000 Mbps normally reached only by negotiation unless strap pins are used.
// - bit 12 enables negotiation, resets to one.
// - isolate alone keeps transmit path to line while link is up.
// - power-down plus isolate blocks MAC transmit inputs and drops the link.
// - isolate resets to zero, one isolates from the MAC interface.
// - bit 9 restarts negotiation when bit 12 is written one with it, and self-clears.
// - bit 7 enables collision test mode, resets to zero.
// - collision test raises col within 512 bit times, lowers within 4; here col falls 3 clocks (15 ns) after transmit enable falls.
// - duplex defaults half, follows bit 8, writes ignored while negotiating.
// - power-down keeps register values; on exit negotiation restarts if enabled.
// - isolate floats MAC outputs, everything else keeps running.
module pmc_mode_ctrl #(
    parameter logic [15:0] STICKY_MASK = pmc_pkg::PMC_STICKY_MASK_DEF,
    parameter int COL_RISE_WAIT = pmc_pkg::PMC_COL_RISE_WAIT
) (
    input wire logic clk_sys, // system clock 200 MHz
    input wire logic reset_n, // hardware reset, async, active low
    input wire logic [4:0] reg_addr, // management register address
    input wire logic [15:0] reg_wdata, // management write data
    input wire logic reg_wr, // management write strobe
    input wire logic reg_rd, // management read strobe
    output logic [15:0] reg_rdata, // read data, valid cycle after strobe
    input wire logic sticky_en, // reset-sticky enable control
    input wire logic mode_pins_used, // speed/duplex/negotiation straps in use
    input wire pmc_pkg::pmc_mac_tx_t mac_tx, // transmit from MAC
    output pmc_pkg::pmc_mac_rx_t mac_rx, // receive to MAC
    output logic mac_rx_oe, // drive enable for MAC receive outputs
    output logic mac_col, // collision to MAC
    output logic mac_col_oe, // drive enable for collision output
    output pmc_pkg::pmc_mac_tx_t line_tx, // transmit toward the line
    input wire pmc_pkg::pmc_mac_rx_t line_rx, // receive from the line
    input wire logic link_up, // link state from the link logic
    input wire pmc_pkg::pmc_speed_t aneg_speed, // negotiated speed
    input wire logic aneg_duplex, // negotiated duplex
    input wire logic [11:0] pair_skew_meas, // measured skew, pair a in top bits
    output pmc_pkg::pmc_speed_t op_speed, // operating speed
    output logic op_duplex, // operating duplex, 1 = full
    output logic aneg_active, // negotiation in use
    output logic aneg_restart, // restart negotiation pulse
    output logic soft_reset, // software reset pulse
    output logic analog_ref_on, // analog references and pll powered
    output logic link_enable, // link allowed up
    output logic power_down // power-down state
);
    import pmc_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        pmc_ctrl_t ctrl;
        logic [15:0] rdata;
        pmc_mac_tx_t tx_s1;
        pmc_mac_tx_t tx_s2;
        pmc_mac_rx_t rx_s1;
        pmc_mac_rx_t rx_s2;
        logic [11:0] skew_s1;
        logic [11:0] skew_s2;
        pmc_mac_rx_t mac_rx;
        pmc_mac_tx_t line_tx;
        pmc_speed_t op_speed;
        logic op_duplex;
        logic aneg_active;
        logic restart;
        logic sw_reset;
        logic pd_prev;
        logic ref_on;
    } pmc_state_t;

    pmc_state_t s;
    pmc_state_t next_s;
    logic col_test_out;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] ofs);
        return a == ofs;
    endfunction : addr_is

    function automatic logic [15:0] skew_word(input logic [11:0] m);
        logic [15:0] w;
        w = 16'h0000;
        for (int p = 0; p < PMC_PAIRS; p++) begin
            w[p*PMC_SKEW_STRIDE +: PMC_SKEW_W] = m[p*PMC_SKEW_W +: PMC_SKEW_W];
        end
        return w;
    endfunction : skew_word

    // ----------------------------------------------------------------
    // collision test
    // ----------------------------------------------------------------
    pmc_col_test #(
        .RISE_WAIT(COL_RISE_WAIT)
    ) u_col_test (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .enable(s.ctrl.col_test),
        .tx_en(s.tx_s2.en),
        .col(col_test_out)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        pmc_ctrl_t wr_ctrl;
        pmc_ctrl_t rst_ctrl;
        logic [15:0] keep;
        logic ctrl_wr;
        logic use_forced;
        logic tx_blocked;
        wr_ctrl = pmc_word_to_ctrl(reg_wdata);
        rst_ctrl = PMC_CTRL_RESET;
        keep = 16'h0000;
        ctrl_wr = reg_wr && addr_is(reg_addr, PMC_OFS_MODE_CTRL);
        use_forced = 1'b0;
        tx_blocked = 1'b0;
        next_s = s;

        // input synchronisers
        next_s.tx_s1 = mac_tx;
        next_s.tx_s2 = s.tx_s1;
        next_s.rx_s1 = line_rx;
        next_s.rx_s2 = s.rx_s1;
        next_s.skew_s1 = pair_skew_meas;
        next_s.skew_s2 = s.skew_s1;

        // references stay on from hardware reset release
        next_s.ref_on = 1'b1;

        // register writes
        next_s.sw_reset = 1'b0;
        next_s.restart = 1'b0;
        if (ctrl_wr && reg_wdata[PMC_B_SW_RESET]) begin
            keep = sticky_en ? STICKY_MASK : 16'h0000;
            rst_ctrl = pmc_word_to_ctrl((pmc_ctrl_to_word(s.ctrl) & keep) |
                                        (pmc_ctrl_to_word(PMC_CTRL_RESET) & ~keep));
            next_s.ctrl = rst_ctrl;
            next_s.sw_reset = 1'b1;
        end else if (ctrl_wr) begin
            next_s.ctrl.loopback = wr_ctrl.loopback;
            next_s.ctrl.speed = wr_ctrl.speed;
            next_s.ctrl.aneg_en = wr_ctrl.aneg_en;
            next_s.ctrl.power_down = wr_ctrl.power_down;
            next_s.ctrl.isolate = wr_ctrl.isolate;
            next_s.ctrl.col_test = wr_ctrl.col_test;
            if (!s.ctrl.aneg_en) begin
                next_s.ctrl.duplex = wr_ctrl.duplex;
            end
            next_s.restart = reg_wdata[PMC_B_ANEG_RESTART] && wr_ctrl.aneg_en;
        end

        // leaving power-down restarts negotiation when bit 12 is set
        next_s.pd_prev = next_s.ctrl.power_down;
        if (s.pd_prev && !next_s.ctrl.power_down && next_s.ctrl.aneg_en) begin
            next_s.restart = 1'b1;
        end

        // register reads; self-clearing bits and reserved bits read zero
        if (reg_rd) begin
            if (addr_is(reg_addr, PMC_OFS_MODE_CTRL)) begin
                next_s.rdata = pmc_ctrl_to_word(s.ctrl);
            end else if (addr_is(reg_addr, PMC_OFS_PAIR_SKEW)) begin
                next_s.rdata = skew_word(s.skew_s2);
            end else begin
                next_s.rdata = 16'h0000;
            end
        end

        // speed and duplex selection
        if (s.ctrl.loopback) begin
            use_forced = 1'b1;
        end else if (!s.ctrl.aneg_en) begin
            use_forced = (s.ctrl.speed != PMC_SPD_1000) || mode_pins_used;
        end
        next_s.aneg_active = !use_forced;
        next_s.op_speed = use_forced ? s.ctrl.speed : aneg_speed;
        next_s.op_duplex = s.ctrl.aneg_en ? aneg_duplex : s.ctrl.duplex;

        // data paths
        tx_blocked = s.ctrl.power_down && s.ctrl.isolate;
        if (s.ctrl.loopback) begin
            next_s.mac_rx = '{dv: s.tx_s2.en, er: s.tx_s2.er, data: s.tx_s2.data};
            next_s.line_tx = '0;
        end else begin
            next_s.mac_rx = s.rx_s2;
            if (!tx_blocked && !s.ctrl.power_down && link_up) begin
                next_s.line_tx = s.tx_s2;
            end else begin
                next_s.line_tx = '0;
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            s <= '{
                ctrl: PMC_CTRL_RESET,
                rdata: 16'h0000,
                tx_s1: '0,
                tx_s2: '0,
                rx_s1: '0,
                rx_s2: '0,
                skew_s1: 12'h000,
                skew_s2: 12'h000,
                mac_rx: '0,
                line_tx: '0,
                op_speed: PMC_SPD_1000,
                op_duplex: 1'b0,
                aneg_active: 1'b1,
                restart: 1'b0,
                sw_reset: 1'b0,
                pd_prev: 1'b0,
                ref_on: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = s.rdata;
    assign mac_rx = s.mac_rx;
    assign mac_rx_oe = !s.ctrl.isolate;
    assign mac_col = col_test_out;
    assign mac_col_oe = !s.ctrl.isolate;
    assign line_tx = s.line_tx;
    assign op_speed = s.op_speed;
    assign op_duplex = s.op_duplex;
    assign aneg_active = s.aneg_active;
    assign aneg_restart = s.restart;
    assign soft_reset = s.sw_reset;
    assign analog_ref_on = s.ref_on;
    assign link_enable = !s.ctrl.power_down;
    assign power_down = s.ctrl.power_down;

endmodule : pmc_mode_ctrl

// *** test/pmc_mode_ctrl_chk.sv ***
`timescale 1ns/1ps
module pmc_mode_ctrl_chk #(
    parameter int COL_RISE_WAIT = pmc_pkg::PMC_COL_RISE_WAIT
) (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic [4:0] reg_addr, // register address
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire pmc_pkg::pmc_mac_tx_t mac_tx, // transmit from mac
    input wire pmc_pkg::pmc_mac_rx_t mac_rx, // receive to mac
    input wire logic mac_rx_oe, // receive drive enable
    input wire logic mac_col, // collision to mac
    input wire logic mac_col_oe, // collision drive enable
    input wire pmc_pkg::pmc_mac_tx_t line_tx, // transmit to line
    input wire logic link_up, // link state
    input wire pmc_pkg::pmc_speed_t aneg_speed, // negotiated speed
    input wire logic aneg_duplex, // negotiated duplex
    input wire pmc_pkg::pmc_speed_t op_speed, // operating speed
    input wire logic op_duplex, // operating duplex
    input wire logic aneg_active, // negotiation in use
    input wire logic aneg_restart, // restart pulse
    input wire logic soft_reset, // software reset pulse
    input wire logic analog_ref_on, // analog references powered
    input wire logic link_enable, // link allowed up
    input wire logic power_down // power-down state
);
    import pmc_pkg::*;
    localparam int RISE_MAX = COL_RISE_WAIT + 8;
    // ----------------------------------------------------------------
    // mirror of the control bits, taken from the write port
    // ----------------------------------------------------------------
    logic lb_q, aneg_q, pd_q, iso_q, ct_q;
    logic [1:0] spd_q;
    logic [1:0] lv_q;
    wire live = (lv_q == 2'h3);
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            {lb_q, spd_q, aneg_q, pd_q, iso_q, ct_q} <= 7'b0_10_1_000;
            lv_q <= 2'h0;
        end else begin
            if (lv_q != 2'h3) begin
                lv_q <= lv_q + 2'h1;
            end
            if (reg_wr && reg_addr == PMC_OFS_MODE_CTRL) begin
                if (reg_wdata[15]) begin
                    {lb_q, spd_q, aneg_q, pd_q, iso_q, ct_q} <= 7'b0_10_1_000;
                end else begin
                    {lb_q, spd_q, aneg_q, pd_q, iso_q, ct_q} <= {reg_wdata[14], reg_wdata[6], reg_wdata[13],
                        reg_wdata[12], reg_wdata[11], reg_wdata[10], reg_wdata[7]};
                end
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    soft_pulse_a: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[15] |=> soft_reset && analog_ref_on)
        else $error("software reset pulse missing");
    restart_pulse_a: assert property (reg_wr && reg_addr == 5'h00 && reg_wdata[9] && reg_wdata[12] && !reg_wdata[15]
        |=> aneg_restart)
        else $error("restart pulse missing");
    loop_echo_a: assert property (live && $past(lb_q) |-> mac_rx == $past(mac_tx, 3) && line_tx == '0)
        else $error("loopback data wrong");
    loop_speed_a: assert property (live && $past(lb_q) |-> op_speed == $past(spd_q))
        else $error("loopback speed not forced");
    aneg_speed_a: assert property (live && $past(aneg_q) && !$past(lb_q)
        |-> op_speed == $past(aneg_speed) && aneg_active && op_duplex == $past(aneg_duplex))
        else $error("negotiated speed not used");
    line_pass_a: assert property (live && !$past(pd_q) && !$past(lb_q) && $past(link_up)
        |-> line_tx == $past(mac_tx, 3))
        else $error("transmit not passed to line");
    pd_block_a: assert property ($past(pd_q) |-> line_tx == '0)
        else $error("power-down does not block");
    link_drop_a: assert property (pd_q |-> !link_enable && power_down)
        else $error("power-down does not drop link");
    iso_oe_a: assert property (iso_q == $past(iso_q) |-> mac_rx_oe == !iso_q && mac_col_oe == !iso_q)
        else $error("isolate drive enables wrong");
    col_rise_a: assert property (ct_q && $rose(mac_tx.en) |-> ##[1:RISE_MAX] mac_col)
        else $error("collision test rise late");
    col_fall_a: assert property ($fell(mac_tx.en) |-> ##[1:6] !mac_col)
        else $error("collision test fall late");
    cover property (soft_reset);
    cover property (ct_q && mac_col);
    cover property (aneg_restart);
    cover property (lb_q && mac_rx.dv);
endmodule : pmc_mode_ctrl_chk

// *** test/pmc_mac_model.sv ***
`timescale 1ns/1ps
module pmc_mac_model (
    input wire logic clk_sys, // system clock
    input wire logic reset_n, // async reset, active low
    input wire logic tx_go, // hold transmit enable high
    output pmc_pkg::pmc_mac_tx_t mac_tx, // transmit toward the block
    output pmc_pkg::pmc_mac_rx_t line_rx // receive from the line side
);
    import pmc_pkg::*;
    logic [7:0] cnt;
    // idle data keeps toggling so stale values never look valid
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 8'h5a;
            mac_tx <= '{en: 1'b0, er: 1'b0, data: 8'ha5};
            line_rx <= '{dv: 1'b0, er: 1'b0, data: 8'h3c};
        end else begin
            cnt <= cnt + 8'h3b;
            mac_tx <= '{en: tx_go, er: cnt[3], data: tx_go ? cnt : ~mac_tx.data};
            line_rx <= '{dv: cnt[0], er: 1'b0, data: ~cnt};
        end
    end
endmodule : pmc_mac_model

// *** test/pmc_mode_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module pmc_mode_ctrl_tb_top;
    import pmc_pkg::*;
    typedef struct packed {
        logic wr;
        logic [4:0] addr;
        logic [15:0] wdata;
        logic [15:0] rexp;
        pmc_speed_t spd;
    } pmc_row_t;
    logic clk_sys, reset_n, reg_wr, reg_rd, sticky_en, mode_pins_used, link_up, aneg_duplex, tx_go;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] pair_skew_meas;
    pmc_mac_tx_t mac_tx, line_tx;
    pmc_mac_rx_t mac_rx, line_rx;
    pmc_speed_t aneg_speed, op_speed;
    logic mac_rx_oe, mac_col, mac_col_oe, op_duplex, aneg_active, aneg_restart;
    logic soft_reset, analog_ref_on, link_enable, power_down;
    int miscompares = 0;
    int check_count = 0;
    pmc_row_t rows [11] = '{
        '{1'b1, 5'h00, 16'h0000, 16'h0000, PMC_SPD_10},
        '{1'b1, 5'h00, 16'h2100, 16'h2100, PMC_SPD_100},
        '{1'b1, 5'h00, 16'h1140, 16'h1140, PMC_SPD_100},
        '{1'b1, 5'h00, 16'h1040, 16'h1140, PMC_SPD_100},
        '{1'b1, 5'h00, 16'h023f, 16'h0100, PMC_SPD_10},
        '{1'b1, 5'h00, 16'h0040, 16'h0040, PMC_SPD_100},
        '{1'b1, 5'h1d, 16'hffff, 16'h5134, PMC_SPD_100},
        '{1'b1, 5'h1e, 16'hffff, 16'h0000, PMC_SPD_100},
        '{1'b1, 5'h1f, 16'hffff, 16'h0000, PMC_SPD_100},
        '{1'b1, 5'h05, 16'hffff, 16'h0000, PMC_SPD_100},
        '{1'b0, 5'h00, 16'h0000, 16'h0040, PMC_SPD_100}
    };
    pmc_mode_ctrl #(.COL_RISE_WAIT(4)) u_pmc_mode_ctrl (.clk_sys, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .sticky_en, .mode_pins_used, .mac_tx, .mac_rx, .mac_rx_oe, .mac_col, .mac_col_oe, .line_tx,
        .line_rx, .link_up, .aneg_speed, .aneg_duplex, .pair_skew_meas, .op_speed, .op_duplex, .aneg_active,
        .aneg_restart, .soft_reset, .analog_ref_on, .link_enable, .power_down);
    pmc_mac_model u_pmc_mac_model (.clk_sys, .reset_n, .tx_go, .mac_tx, .line_rx);
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [15:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        chk(reg_rdata, e, "read data");
    endtask : rd
    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        miscompares++;
        end_sim();
    end
    initial begin
        pmc_mac_tx_t t;
        {reset_n, reg_wr, reg_rd, sticky_en, mode_pins_used, tx_go, aneg_duplex} = 7'h1;
        {reg_addr, reg_wdata} = 21'h0;
        link_up = 1'b1;
        aneg_speed = PMC_SPD_100;
        pair_skew_meas = 12'ha5c;
        repeat (4) @(posedge clk_sys);
        #1;
        chk(16'(analog_ref_on), 16'h0, "analog on in reset");
        reset_n = 1'b1;
        cyc(1);
        rd(5'h00, 16'h1040);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].addr, rows[i].wdata);
            end
            rd(rows[i].addr, rows[i].rexp);
            chk(16'(op_speed), 16'(rows[i].spd), "speed");
        end
        mode_pins_used = 1'b1;
        cyc(2);
        chk(16'(op_speed), 16'(PMC_SPD_1000), "strap speed");
        chk(16'(aneg_active), 16'h0, "strap forced");
        chk(16'(op_duplex), 16'h0, "forced half");
        mode_pins_used = 1'b0;
        tx_go = 1'b1;
        for (int s = 0; s < 3; s++) begin
            wr(5'h00, 16'h5000 | (s[1] ? 16'h0040 : 16'h0) | (s[0] ? 16'h2000 : 16'h0));
            cyc(4);
            t = mac_tx;
            cyc(3);
            chk(16'(mac_rx), 16'(t), "loop data");
            chk(16'(line_tx), 16'h0, "line quiet");
            chk(16'(op_speed), 16'(s), "loop speed");
        end
        tx_go = 1'b0;
        wr(5'h00, 16'h4080);
        cyc(8);
        tx_go = 1'b1;
        for (int k = 0; k < 12 && !mac_col; k++) cyc(1);
        chk(16'(mac_col), 16'h1, "collision rise");
        tx_go = 1'b0;
        cyc(6);
        chk(16'(mac_col), 16'h0, "collision fall");
        tx_go = 1'b1;
        wr(5'h00, 16'h0400);
        cyc(4);
        t = mac_tx;
        cyc(3);
        chk(16'(line_tx), 16'(t), "isolate passes line");
        chk(16'(mac_col_oe), 16'h0, "isolate float");
        chk(16'(mac_rx_oe), 16'h0, "isolate rx float");
        wr(5'h00, 16'h0c00);
        cyc(2);
        chk(16'(line_tx), 16'h0, "power-down line");
        chk(16'(link_enable), 16'h0, "link drop");
        wr(5'h00, 16'h1000);
        chk(16'(aneg_restart), 16'h1, "exit restart");
        cyc(1);
        wr(5'h00, 16'h1200);
        chk(16'(aneg_restart), 16'h1, "restart");
        rd(5'h00, 16'h1000);
        sticky_en = 1'b1;
        wr(5'h00, 16'h8000);
        chk(16'(soft_reset), 16'h1, "soft reset");
        chk(16'(analog_ref_on), 16'h1, "analog kept");
        rd(5'h00, 16'h1040);
        chk(16'(soft_reset), 16'h0, "soft reset pulse");
        reset_n = 1'b0;
        cyc(2);
        chk(16'(analog_ref_on), 16'h0, "hw reset analog");
        reset_n = 1'b1;
        cyc(1);
        rd(5'h00, 16'h1040);
        end_sim();
    end
endmodule : pmc_mode_ctrl_tb_top
bind pmc_mode_ctrl pmc_mode_ctrl_chk #(.COL_RISE_WAIT(COL_RISE_WAIT)) u_pmc_mode_ctrl_chk (.clk_sys, .reset_n,
    .reg_addr, .reg_wdata, .reg_wr, .mac_tx, .mac_rx, .mac_rx_oe, .mac_col, .mac_col_oe, .line_tx, .link_up,
    .aneg_speed, .aneg_duplex, .op_speed, .op_duplex, .aneg_active, .aneg_restart, .soft_reset, .analog_ref_on,
    .link_enable, .power_down);
